//--- sdisp_pkg.sv
package sdisp_pkg;
  // Character codes the parser reacts to.
  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_STAR  = 8'h2a;
  localparam logic [7:0] CHAR_DOLR  = 8'h24;
  localparam logic [7:0] CHAR_LEAD  = 8'h4e;
  localparam logic [7:0] CHAR_SECT  = 8'h23;
  localparam logic [7:0] CHAR_SELT  = 8'h40;
  localparam logic [7:0] CHAR_BRIT  = 8'h25;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
  localparam logic [7:0] CHAR_ONE   = 8'h31;
  localparam logic [7:0] CHAR_TWO   = 8'h32;
  localparam logic [7:0] CHAR_FIVE  = 8'h35;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_NONE  = 8'h00;
  localparam logic [7:0] DEC_BASE   = 8'h0a;
  // Sizes.
  localparam int RX_DEPTH = 64;
  localparam int DISP_LEN = 6;
  localparam logic [6:0] ADDR_HDR_LEN = 7'h03;
  // Timing: a 10 ms delay step at a 50 MHz clock.
  localparam int CLK_HZ   = 50000000;
  localparam int TICK_MS  = 10;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [6:0]  HUND_LAST = 7'h63;
  localparam logic [5:0]  SEC_MAX   = 6'h3b;
  localparam logic [6:0]  CENT_MAX  = 7'h63;
  localparam logic [12:0] HUND_SEC  = 13'h0064;
  // Values after reset.
  localparam logic [2:0]  BRIGHT_RST = 3'h5;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  // Controller register offsets and fields.
  localparam logic [7:0] OFS_TXDATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam int CTRL_HOLD  = 0;
  localparam int CTRL_ADDR  = 1;
  localparam int CTRL_UNIT  = 8;
  typedef enum logic [1:0] {
    RX_COLLECT = 2'b00,
    RX_PROCESS = 2'b01,
    RX_BLOCKED = 2'b11
  } rx_state_t;
endpackage : sdisp_pkg

//--- sdisp_link_if.sv
`timescale 1ns/1ns
interface sdisp_link_if;
  logic       chr_valid;
  logic [7:0] chr_data;
  logic       rx_blocked;
  modport host (output chr_valid, output chr_data, input rx_blocked);
  modport device (input chr_valid, input chr_data, output rx_blocked);
endinterface : sdisp_link_if

//--- char_seg.sv
`timescale 1ns/1ns
module char_seg
  import sdisp_pkg::*;
(
  input  wire logic [7:0] chr_i,
  output logic      [7:0] seg_o
);
  logic [7:0] up;
  always_comb
  begin
    up = (chr_i >= 8'h61 && chr_i <= 8'h7a) ? (chr_i & 8'hdf) : chr_i;
    case (chr_i)
      // Lower case forms with their own entry; b, d, q, r and t give the same pattern as upper case.
      8'h62: seg_o = 8'h7c;
      8'h63: seg_o = 8'h58;
      8'h64: seg_o = 8'h5e;
      8'h65: seg_o = 8'h7b;
      8'h67: seg_o = 8'h6f;
      8'h68: seg_o = 8'h74;
      8'h69: seg_o = 8'h10;
      8'h6c: seg_o = 8'h06;
      8'h6e: seg_o = 8'h54;
      8'h6f: seg_o = 8'h5c;
      8'h71: seg_o = 8'h67;
      8'h72: seg_o = 8'h50;
      8'h74: seg_o = 8'h78;
      8'h75: seg_o = 8'h1c;
      8'h76: seg_o = 8'h1c;
      8'h2e, 8'h2c, 8'h3a: seg_o = 8'h80;
      8'h2d: seg_o = 8'h40;
      default:
        case (up)
          8'h30: seg_o = 8'h3f;
          8'h31: seg_o = 8'h06;
          8'h32: seg_o = 8'h5b;
          8'h33: seg_o = 8'h4f;
          8'h34: seg_o = 8'h66;
          8'h35: seg_o = 8'h6d;
          8'h36: seg_o = 8'h7d;
          8'h37: seg_o = 8'h07;
          8'h38: seg_o = 8'h7f;
          8'h39: seg_o = 8'h6f;
          8'h41: seg_o = 8'h77;
          8'h42: seg_o = 8'h7c;
          8'h43: seg_o = 8'h39;
          8'h44: seg_o = 8'h5e;
          8'h45: seg_o = 8'h79;
          8'h46: seg_o = 8'h71;
          8'h47: seg_o = 8'h3d;
          8'h48: seg_o = 8'h76;
          8'h49: seg_o = 8'h30;
          8'h4a: seg_o = 8'h1e;
          8'h4b: seg_o = 8'h75;
          8'h4c: seg_o = 8'h38;
          8'h4e: seg_o = 8'h37;
          8'h4f: seg_o = 8'h3f;
          8'h50: seg_o = 8'h73;
          8'h51: seg_o = 8'h67;
          8'h52: seg_o = 8'h50;
          8'h53: seg_o = 8'h6d;
          8'h54: seg_o = 8'h78;
          8'h55: seg_o = 8'h3e;
          8'h56: seg_o = 8'h3e;
          8'h59: seg_o = 8'h6e;
          8'h5a: seg_o = 8'h5b;
          // Space, M, W, X and anything else stay dark.
          default: seg_o = 8'h00;
        endcase
    endcase
  end
endmodule : char_seg

//--- sdisp_device.sv
`timescale 1ns/1ns
// Functional notes
// - Digits and listed letters drive segment patterns.
// - Letters without segment form show blank.
// - Both cases accepted, shown as received; lower case letters without their own entry show the upper case pattern.
// - Period comma colon light point; dash; blank.
// - Right aligned six positions, last six shown.
// - Two buffers; secondary shown marks a 2.
// - Switch display manually, by interval, by command.
// - Both buffers kept in non-volatile storage.
// - 64-char buffer, excess dropped until terminator.
// - Only carriage return ends a string.
// - Asterisk or dollar clears pending string.
// - Host sends lead, then two address digits.
// - No tag main, hash tag secondary.
// - At-sign 1 or 2 selects shown display.
// - Percent 1 to 5 sets brightness.
// - Reception stops for delay after terminator.
// - Delay programmable, at least 10 ms.
// - Characters during delay are ignored.
// - Host lets delay end on idle line.
// - Unit address 0 to 99, shared addresses allowed.
// - Delay in seconds and hundredths, max 59.99.
// - Leading zero blanking, main display only.
module sdisp_device
  import sdisp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  sdisp_link_if.device     lnk,
  input  wire logic [6:0]  unit_addr_i,
  input  wire logic [5:0]  delay_sec_i,
  input  wire logic [6:0]  delay_cent_i,
  input  wire logic        sec_en_i,
  input  wire logic        lead_zero_en_i,
  input  wire logic [3:0]  scroll_sec_i,
  input  wire logic        sel_toggle_i,
  input  wire logic        nv_restore_i,
  input  wire logic [47:0] nv_main_i,
  input  wire logic [47:0] nv_sec_i,
  output logic      [47:0] disp_seg_o,
  output logic      [7:0]  mark_seg_o,
  output logic             show_sec_o,
  output logic      [2:0]  bright_o,
  output logic      [47:0] main_chars_o,
  output logic      [47:0] sec_chars_o,
  output logic             nv_write_o
);
  rx_state_t            state;
  logic [7:0]           rx_mem [RX_DEPTH];
  logic [6:0]           rx_cnt;
  logic [31:0]          tick_cnt;
  logic                 tick;
  logic [12:0]          dly_len;
  logic [12:0]          dly_cnt;
  logic [6:0]           sc_hund;
  logic [3:0]           sc_sec;
  logic                 rx_take;
  logic                 has_addr;
  logic                 addr_ok;
  logic [7:0]           tens;
  logic [7:0]           ones;
  logic [6:0]           tag_pos;
  logic [6:0]           dstart;
  logic [6:0]           idx;
  logic [7:0]           tag;
  logic [7:0]           arg;
  logic                 lead;
  logic [5:0][7:0]      text;
  logic [5:0][7:0]      ztext;
  logic                 do_main;
  logic                 do_sec;
  logic                 do_sel;
  logic                 do_brt;
  logic [5:0][7:0]      shown;
  logic [47:0]          next_seg;
  logic [7:0]           two_seg;
  logic [5:0]           sec_clip;
  logic [6:0]           cent_clip;
  logic [12:0]          next_dly;

  ////////////////////////////////////////////////////////////////////////////
  // Reception and string collection.
  assign rx_take = lnk.chr_valid && (state == RX_COLLECT);

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state <= RX_COLLECT;
    else
      case (state)
        RX_COLLECT:
          if (rx_take && lnk.chr_data == CHAR_CR)
            state <= RX_PROCESS;
        RX_PROCESS:
          state <= RX_BLOCKED;
        RX_BLOCKED:
          if (tick && (dly_cnt + 13'h0001 >= dly_len))
            state <= RX_COLLECT;
        default:
          state <= RX_COLLECT;
      endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rx_cnt <= 7'h00;
    else if (state == RX_PROCESS)
      rx_cnt <= 7'h00;
    else if (rx_take && (lnk.chr_data == CHAR_STAR || lnk.chr_data == CHAR_DOLR))
      rx_cnt <= 7'h00;
    else if (rx_take && lnk.chr_data != CHAR_CR && rx_cnt < 7'(RX_DEPTH))
      rx_cnt <= rx_cnt + 7'h01;
  end

  // Buffer contents need no reset: only the first rx_cnt entries are read.
  always_ff @(posedge sys_clk_i)
  begin
    if (rx_take && rx_cnt < 7'(RX_DEPTH))
      rx_mem[rx_cnt[5:0]] <= lnk.chr_data;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lnk.rx_blocked <= 1'b0;
    else
      lnk.rx_blocked <= (state == RX_COLLECT) ? rx_take && lnk.chr_data == CHAR_CR
                        : !(state == RX_BLOCKED && tick && dly_cnt + 13'h0001 >= dly_len);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of the collected string.
  always_comb
  begin
    has_addr = rx_cnt >= ADDR_HDR_LEN && rx_mem[0] == CHAR_LEAD;
    tens = rx_mem[1] - CHAR_ZERO;
    ones = rx_mem[2] - CHAR_ZERO;
    addr_ok = !has_addr || (tens < DEC_BASE && ones < DEC_BASE
              && 8'(tens * DEC_BASE) + ones == {1'b0, unit_addr_i});
    tag_pos = has_addr ? ADDR_HDR_LEN : 7'h00;
    tag = (rx_cnt > tag_pos) ? rx_mem[tag_pos[5:0]] : CHAR_NONE;
    arg = (rx_cnt > tag_pos + 7'h01) ? rx_mem[6'(tag_pos + 7'h01)] : CHAR_NONE;
    dstart = tag_pos + ((tag == CHAR_SECT) ? 7'h01 : 7'h00);
    for (int k = 0; k < DISP_LEN; k++)
    begin
      idx = rx_cnt - 7'h01 - 7'(k);
      text[k] = (rx_cnt >= dstart + 7'(k + 1)) ? rx_mem[idx[5:0]] : CHAR_SPACE;
    end
    ztext = text;
    lead = 1'b1;
    // The rightmost position is never blanked, so a zero value still shows.
    for (int k = DISP_LEN - 1; k > 0; k--)
    begin
      if (lead && text[k] == CHAR_ZERO)
        ztext[k] = CHAR_SPACE;
      else if (text[k] != CHAR_SPACE)
        lead = 1'b0;
    end
  end

  assign do_sel  = state == RX_PROCESS && addr_ok && tag == CHAR_SELT;
  assign do_brt  = state == RX_PROCESS && addr_ok && tag == CHAR_BRIT;
  assign do_sec  = state == RX_PROCESS && addr_ok && tag == CHAR_SECT;
  assign do_main = state == RX_PROCESS && addr_ok && !do_sel && !do_brt && !do_sec;

  ////////////////////////////////////////////////////////////////////////////
  // Display buffers and settings.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      main_chars_o <= {DISP_LEN{CHAR_SPACE}};
      sec_chars_o  <= {DISP_LEN{CHAR_SPACE}};
    end
    else if (nv_restore_i)
    begin
      main_chars_o <= nv_main_i;
      sec_chars_o  <= nv_sec_i;
    end
    else if (do_main)
      main_chars_o <= lead_zero_en_i ? text : ztext;
    else if (do_sec)
      sec_chars_o <= text;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      nv_write_o <= 1'b0;
    else
      nv_write_o <= do_main || do_sec;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bright_o <= BRIGHT_RST;
    else if (do_brt && arg >= CHAR_ONE && arg <= CHAR_FIVE)
      bright_o <= 3'(arg - CHAR_ZERO);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      show_sec_o <= 1'b0;
    else if (!sec_en_i)
      show_sec_o <= 1'b0;
    else if (do_sel && arg == CHAR_ONE)
      show_sec_o <= 1'b0;
    else if (do_sel && arg == CHAR_TWO)
      show_sec_o <= 1'b1;
    else if (sel_toggle_i)
      show_sec_o <= !show_sec_o;
    else if (tick && sc_hund == HUND_LAST && scroll_sec_i != 4'h0
             && sc_sec + 4'h1 >= scroll_sec_i)
      show_sec_o <= !show_sec_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one 10 ms tick serves both the delay and the scroll interval.
  // The tick restarts at each terminator so the delay is never short; the
  // scroll interval may stretch by up to one tick as a result.
  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tick_cnt <= 32'h0;
    else if (tick || state == RX_PROCESS)
      tick_cnt <= 32'h0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  always_comb
  begin
    sec_clip  = (delay_sec_i > SEC_MAX) ? SEC_MAX : delay_sec_i;
    cent_clip = (delay_cent_i > CENT_MAX) ? CENT_MAX : delay_cent_i;
    next_dly  = 13'(sec_clip * HUND_SEC) + 13'(cent_clip);
    if (next_dly == 13'h0)
      next_dly = 13'h0001;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dly_len <= 13'h0001;
      dly_cnt <= 13'h0;
    end
    else if (state == RX_PROCESS)
    begin
      dly_len <= next_dly;
      dly_cnt <= 13'h0;
    end
    else if (tick)
      dly_cnt <= dly_cnt + 13'h0001;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sc_hund <= 7'h00;
      sc_sec  <= 4'h0;
    end
    else if (!sec_en_i || do_sel || sel_toggle_i)
    begin
      sc_hund <= 7'h00;
      sc_sec  <= 4'h0;
    end
    else if (tick && sc_hund == HUND_LAST)
    begin
      sc_hund <= 7'h00;
      sc_sec  <= (sc_sec + 4'h1 >= scroll_sec_i) ? 4'h0 : sc_sec + 4'h1;
    end
    else if (tick)
      sc_hund <= sc_hund + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment drive.
  assign shown = show_sec_o ? sec_chars_o : main_chars_o;

  for (genvar g = 0; g < DISP_LEN; g++)
  begin : g_seg
    char_seg u_seg (
      .chr_i (shown[g]),
      .seg_o (next_seg[g*8 +: 8])
    );
  end

  char_seg u_mark (
    .chr_i (CHAR_TWO),
    .seg_o (two_seg)
  );

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      disp_seg_o <= 48'h0;
      mark_seg_o <= 8'h00;
    end
    else
    begin
      disp_seg_o <= next_seg;
      mark_seg_o <= show_sec_o ? two_seg : 8'h00;
    end
  end
endmodule : sdisp_device

//--- sdisp_host.sv
`timescale 1ns/1ns
module sdisp_host
  import sdisp_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  sdisp_link_if.host       lnk
);
  logic [31:0] ctrl;
  logic [7:0]  tx_char;
  logic        pending;
  logic        at_start;
  logic [1:0]  pre_step;
  logic        cr_sent;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        may_send;
  logic [6:0]  unit;
  logic [7:0]  out_chr;
  logic        sending;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: no wait states, always OKAY.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      wr_pend <= hsel_i && hready_i && htrans_i[1] && hwrite_i && hsize_i == 3'h2;
      wr_addr <= haddr_i[7:0];
      if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
        case (haddr_i[7:0])
          OFS_STATUS: hrdata_o <= {29'h0, cr_sent, lnk.rx_blocked, pending};
          OFS_CTRL:   hrdata_o <= ctrl;
          default:    hrdata_o <= 32'h0;
        endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl <= CTRL_RST;
    else if (wr_pend && wr_addr == OFS_CTRL)
      ctrl <= {17'h0, hwdata_i[14:8], 6'h0, hwdata_i[1:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character sender. A write to the data register while a character is
  // still pending is dropped; software polls the pending flag first.
  assign unit = ctrl[CTRL_UNIT +: 7];
  // With hold enabled, nothing is sent from a terminator until the far end
  // has closed and reopened reception, so the delay ends on an idle line.
  assign may_send = pending && !(ctrl[CTRL_HOLD] && (lnk.rx_blocked || cr_sent));
  assign sending = may_send && !lnk.chr_valid;

  always_comb
  begin
    out_chr = tx_char;
    if (at_start && ctrl[CTRL_ADDR])
      case (pre_step)
        2'h0:    out_chr = CHAR_LEAD;
        2'h1:    out_chr = CHAR_ZERO + 8'(unit / 7'(DEC_BASE));
        2'h2:    out_chr = CHAR_ZERO + 8'(unit % 7'(DEC_BASE));
        default: out_chr = tx_char;
      endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pending <= 1'b0;
      tx_char <= 8'h00;
    end
    else if (wr_pend && wr_addr == OFS_TXDATA && !pending)
    begin
      pending <= 1'b1;
      tx_char <= hwdata_i[7:0];
    end
    else if (sending && (!at_start || !ctrl[CTRL_ADDR] || pre_step == 2'h3))
      pending <= 1'b0;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      at_start <= 1'b1;
      pre_step <= 2'h0;
    end
    else if (sending && at_start && ctrl[CTRL_ADDR] && pre_step != 2'h3)
      pre_step <= pre_step + 2'h1;
    else if (sending)
    begin
      at_start <= tx_char == CHAR_CR || tx_char == CHAR_STAR || tx_char == CHAR_DOLR;
      pre_step <= 2'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cr_sent <= 1'b0;
    else if (lnk.rx_blocked)
      cr_sent <= 1'b0;
    else if (sending && out_chr == CHAR_CR)
      cr_sent <= 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lnk.chr_valid <= 1'b0;
      lnk.chr_data  <= 8'h00;
    end
    else
    begin
      lnk.chr_valid <= sending;
      if (sending)
        lnk.chr_data <= out_chr;
    end
  end
endmodule : sdisp_host

//--- sdisp_link_properties.sv
`timescale 1ns/1ns
module sdisp_link_properties
  import sdisp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       chr_valid,
  input  wire logic [7:0] chr_data,
  input  wire logic       rx_blocked
);
  // Wide enough for the longest delay at the full-speed tick.
  localparam longint MAX_BLK = 5999 * longint'(TICK_CYCLES) + 2;
  logic [31:0] blk_len;
  logic        cr_taken;
  ////////////////////////////////////////
  // A counter stands in for a long repetition, which the tools would unroll.
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      blk_len <= 32'h0;
    else if (rx_blocked)
      blk_len <= blk_len + 32'h1;
    else
      blk_len <= 32'h0;
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cr_taken <= 1'h0;
    else
      cr_taken <= chr_valid && chr_data == CHAR_CR && !rx_blocked;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_cr_blocks:
    assert property (chr_valid && chr_data == CHAR_CR && !rx_blocked |=> rx_blocked)
    else $error("no block after terminator");
  a_idle_stays_open:
    assert property (!rx_blocked && !(chr_valid && chr_data == CHAR_CR) |=> !rx_blocked)
    else $error("block without terminator");
  a_rise_has_cause:
    assert property ($rose(rx_blocked) |-> cr_taken)
    else $error("block rose with no terminator taken");
  a_block_min_len:
    assert property ($fell(rx_blocked) |-> blk_len >= TICK_CYCLES)
    else $error("block shorter than one tick");
  a_block_max_len:
    assert property (rx_blocked |-> blk_len <= MAX_BLK)
    else $error("block longer than the largest delay");
  a_strobe_pulse:
    assert property (chr_valid |=> !chr_valid)
    else $error("character strobe held two cycles");
  a_data_holds:
    assert property (!chr_valid |-> $stable(chr_data))
    else $error("character data moved without strobe");
  a_fall_gap:
    assert property ($fell(rx_blocked) && !(chr_valid && chr_data == CHAR_CR) |=> !rx_blocked)
    else $error("block returned at once");
  c_block: cover property ($rose(rx_blocked));
  c_char_dropped: cover property (rx_blocked && chr_valid);
  c_clear: cover property (chr_valid && chr_data == CHAR_STAR);
endmodule : sdisp_link_properties

//--- tb_serial_display_command_parser.sv
`timescale 1ns/1ns
module tb_serial_display_command_parser
  import sdisp_pkg::*;
;
  typedef struct {string tx; string mn; string sc; logic [2:0] br; logic ss;} row_t;
  localparam int TICKS = 20;
  logic        sys_clk = 1'h0, rst_b = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, bright;
  logic [6:0]  unit_addr = 7'h05, delay_cent = 7'h01;
  logic [5:0]  delay_sec = 6'h00;
  logic        sec_en = 1'h1, lead_zero_en = 1'h1, show_sec, nv_write;
  logic [47:0] disp_seg, main_chars, sec_chars, nv_main = 48'h0, nv_sec = 48'h0;
  logic        sel_toggle = 1'h0, nv_restore = 1'h0;
  logic [3:0]  scroll_sec = 4'h0;
  logic [7:0]  mark_seg;
  int          errors = 0, total_checks = 0, nv_cnt = 0, cyc = 0;
  // Each row leaves state that the next row builds on, so order matters.
  row_t rows[17] = '{'{"12", "12", "", 3'h5, 1'h0}, '{"#Ab", "12", "Ab", 3'h5, 1'h0},
    '{"1234567", "234567", "Ab", 3'h5, 1'h0}, '{"%1", "234567", "Ab", 3'h1, 1'h0},
    '{"%2", "234567", "Ab", 3'h2, 1'h0}, '{"%4", "234567", "Ab", 3'h4, 1'h0},
    '{"%5", "234567", "Ab", 3'h5, 1'h0}, '{"%3", "234567", "Ab", 3'h3, 1'h0},
    '{"%7", "234567", "Ab", 3'h3, 1'h0}, '{"@2", "234567", "Ab", 3'h3, 1'h1},
    '{"@3", "234567", "Ab", 3'h3, 1'h1}, '{"@1", "234567", "Ab", 3'h3, 1'h0},
    '{"12*34", "34", "Ab", 3'h3, 1'h0}, '{"5$6", "6", "Ab", 3'h3, 1'h0},
    '{"N0599", "99", "Ab", 3'h3, 1'h0}, '{"N07#77", "99", "Ab", 3'h3, 1'h0},
    '{"N05#42", "99", "42", 3'h3, 1'h0}};
  ////////////////////////////////////////
  sdisp_link_if lnk_if ();
  sdisp_host sdisp_host_i (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .lnk(lnk_if.host));
  sdisp_device #(.TICK_CYCLES(TICKS)) sdisp_device_i (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .lnk(lnk_if.device), .unit_addr_i(unit_addr), .delay_sec_i(delay_sec),
    .delay_cent_i(delay_cent), .sec_en_i(sec_en), .lead_zero_en_i(lead_zero_en),
    .scroll_sec_i(scroll_sec), .sel_toggle_i(sel_toggle), .nv_restore_i(nv_restore),
    .nv_main_i(nv_main), .nv_sec_i(nv_sec), .disp_seg_o(disp_seg), .mark_seg_o(mark_seg),
    .show_sec_o(show_sec),
    .bright_o(bright), .main_chars_o(main_chars), .sec_chars_o(sec_chars),
    .nv_write_o(nv_write));
  sdisp_link_properties #(.TICK_CYCLES(TICKS)) sdisp_link_properties_i (.sys_clk_i(sys_clk),
    .rst_b_i(rst_b), .chr_valid(lnk_if.chr_valid), .chr_data(lnk_if.chr_data),
    .rx_blocked(lnk_if.rx_blocked));
  always #10 sys_clk = ~sys_clk;
  // The store pulse lasts one cycle, so it is counted rather than looked at.
  always @(posedge sys_clk)
    if (nv_write === 1'h1)
      nv_cnt++;
  ////////////////////////////////////////
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Every wait is bounded so a hung design ends in the report, not a stall.
  task wait_lvl(input logic blk, input logic lvl);
    int n;
    n = 0;
    while (((blk ? lnk_if.rx_blocked : hready) !== lvl) && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000)
    begin
      chk("wait", {47'h0, lvl}, {47'h0, ~lvl});
      print_verdict();
    end
  endtask : wait_lvl
  task ahb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    hsel <= 1'h1;
    haddr <= {24'h0, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk);
    wait_lvl(1'h0, 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    wait_lvl(1'h0, 1'h1);
    rd = hrdata;
  endtask : ahb
  task send_char(input logic [7:0] c);
    int n;
    n = 0;
    ahb(1'h0, OFS_STATUS, 32'h0);
    while (rd[0] !== 1'h0 && n < 3000)
    begin
      ahb(1'h0, OFS_STATUS, 32'h0);
      n++;
    end
    chk("pending", 48'h0, {47'h0, rd[0]});
    if (n >= 3000)
      print_verdict();
    ahb(1'h1, OFS_TXDATA, {24'h0, c});
  endtask : send_char
  task send_str(input string s);
    for (int i = 0; i < s.len(); i++)
      send_char(s[i]);
    send_char(CHAR_CR);
    wait_lvl(1'h1, 1'h1);
    wait_lvl(1'h1, 1'h0);
    repeat (3) @(posedge sys_clk);
  endtask : send_str
  function automatic logic [47:0] f6(input string s);
    logic [47:0] v;
    v = {6{CHAR_SPACE}};
    for (int k = 0; k < 6 && k < s.len(); k++)
      v[8*k +: 8] = s[s.len() - 1 - k];
    return v;
  endfunction : f6
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge sys_clk);
    chk("main_rst", f6(""), main_chars);
    chk("bright_rst", 48'h5, {45'h0, bright});
    chk("seg_rst", 48'h0, disp_seg);
    rst_b <= 1'h1;
    @(posedge sys_clk);
    ahb(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl", 48'h1, {16'h0, rd});
    ahb(1'h0, 8'h0c, 32'h0);
    chk("unmapped", 48'h0, {16'h0, rd});
    chk("hresp", 48'h0, {47'h0, hresp});
    foreach (rows[i])
    begin
      send_str(rows[i].tx);
      chk("main", f6(rows[i].mn), main_chars);
      chk("sec", f6(rows[i].sc), sec_chars);
      chk("bright", {45'h0, rows[i].br}, {45'h0, bright});
      chk("show", {47'h0, rows[i].ss}, {47'h0, show_sec});
      chk("mark", rows[i].ss ? 48'h5b : 48'h0, {40'h0, mark_seg});
    end
    chk("nv_writes", 48'h7, 48'(nv_cnt));
    // Seventy characters: only the first 64 are kept, so 58 to 63 show.
    for (int i = 0; i < 70; i++)
      send_char(CHAR_ZERO + 8'(i % 10));
    send_str("");
    chk("overflow", f6("890123"), main_chars);
    // Without hold the host pushes a digit into the blocked window.
    ahb(1'h1, OFS_CTRL, 32'h0);
    send_char(8'h37);
    send_char(CHAR_CR);
    send_char(8'h35);
    wait_lvl(1'h1, 1'h0);
    ahb(1'h1, OFS_CTRL, 32'h1);
    send_str("8");
    chk("dropped", f6("8"), main_chars);
    lead_zero_en <= 1'h0;
    send_str("0012");
    chk("lead_blank", 48'h0, {16'h0, disp_seg[47:16]});
    send_str("cCM.-7");
    chk("segs", 48'h5839_0080_4007, disp_seg);
    // Auto address with unit 5: the host puts the header in front by itself.
    ahb(1'h1, OFS_CTRL, 32'h0000_0503);
    ahb(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl_rw", 48'h503, {16'h0, rd});
    send_str("#31");
    chk("addressed", f6("31"), sec_chars);
    nv_main <= f6("9");
    nv_sec <= f6("8");
    nv_restore <= 1'h1;
    @(posedge sys_clk);
    nv_restore <= 1'h0;
    @(posedge sys_clk);
    chk("nv_main", f6("9"), main_chars);
    chk("nv_sec", f6("8"), sec_chars);
    sel_toggle <= 1'h1;
    @(posedge sys_clk);
    sel_toggle <= 1'h0;
    repeat (2) @(posedge sys_clk);
    chk("toggle", 48'h1, {47'h0, show_sec});
    sec_en <= 1'h0;
    repeat (2) @(posedge sys_clk);
    chk("sec_off", 48'h0, {47'h0, show_sec});
    // One second is 100 ticks; the free-running tick phase takes off up to one tick.
    sec_en <= 1'h1;
    scroll_sec <= 4'h1;
    @(posedge sys_clk);
    while (show_sec !== 1'h1 && cyc < 3000)
    begin
      @(posedge sys_clk);
      cyc++;
    end
    chk("scroll", 48'h1, {47'h0, cyc >= 99 * TICKS && cyc <= 100 * TICKS});
    print_verdict();
  end
endmodule : tb_serial_display_command_parser
